/* logic/rpl_device.sv */
// Purpose: Protection lock of a serial memory: unlock, read permit, password
// Assumes: SPI mode 0, single-bit transfers, link pins sampled on clk_i
// Notes: Commands act when chip select rises; reads answer on the fly
//
// Behaviour
// [RULE_01] Guarded program/erase only while unlock bit set
// [RULE_02] Lock command clears unlock; host locks last
// [RULE_03] Lock-down mode: hardware reset sets unlock
// [RULE_04] Lock-down mode: no command re-sets unlock
// [RULE_05] Password mode: reset clears, only unlock sets
// [RULE_06] Permanent mode: unlock 0, read permit 1
// [RULE_07] Region 3 read undefined without read permit
// [RULE_08] Password mode: any reset loads read permit
// [RULE_09] Exact 64-bit password match sets unlock
// [RULE_10] Password programming only clears bits, silently
// [RULE_11] Password space all ones, readable before lockout
// [RULE_12] Password mode bit locks out password access
// [RULE_13] Mismatch: error flag, busy, stays locked
// [RULE_14] One unlock per 100 us, host polls busy
// [RULE_15] Matching password skips throttle delay
// [RULE_16] Read protection only enforced in password mode
// [RULE_17] Mode bits cannot be erased
// [RULE_18] Host drives select/clock/input, device drives output
// [RULE_19] Select low frames command; rise ends it
// [RULE_20] Partial-byte commands are discarded
// [RULE_21] Lock A6h, password unlock EAh
// [RULE_22] One mode bit chosen, later config writes fail
// [RULE_23] Truncated unlock leaves unlock bit unchanged
`timescale 1ns/10ps
`default_nettype none

module rpl_device
  import rpl_pkg::*;
#(
  parameter int unsigned THROTTLE_CYC = THROTTLE_CYC_DEF
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  rpl_link_if.device link,
  input wire logic [7:0] sr3_data_i,
  output logic region_write_unlock_o,
  output logic region3_read_permit_o,
  output logic guarded_op_o,
  output logic [7:0] guarded_op_code_o,
  output logic write_in_progress_o,
  output logic program_error_flag_o
);

  generate
    if (THROTTLE_CYC < 2)
    begin : g_bad_throttle
      $error("THROTTLE_CYC must be at least 2");
    end
  endgenerate

  function automatic rpl_mode_t cfg_mode(input logic [7:0] cfg);
    if (!cfg[CFG_MODE_PERM])
      return RPL_MODE_PERMANENT;
    else if (!cfg[CFG_MODE_PASS])
      return RPL_MODE_PASSWORD;
    else
      return RPL_MODE_LOCKDOWN;
  endfunction : cfg_mode

  // ==========================================================
  // Pin synchronisers: {rst_n, cs_n, sck, si}
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic sck_d_ff;
  logic cs_d_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= {link.rst_n, link.cs_n, link.sck, link.io[IO_SI]};
      sync2_ff <= sync1_ff;
      sck_d_ff <= sync2_ff[1];
      cs_d_ff <= sync2_ff[2];
    end
  end

  logic hw_rst;
  logic cs_n_s;
  logic sck_rise;
  logic sck_fall;
  logic si_s;
  logic cs_rise;
  assign hw_rst = !sync2_ff[3];
  assign cs_n_s = sync2_ff[2];
  assign si_s = sync2_ff[0];
  assign sck_rise = !cs_n_s && sync2_ff[1] && !sck_d_ff;
  assign sck_fall = !cs_n_s && !sync2_ff[1] && sck_d_ff;
  assign cs_rise = cs_n_s && !cs_d_ff; // RULE_19

  // ==========================================================
  // Bit counter and receive shifter
  logic [7:0] bitcnt_ff;
  logic [63:0] rx_ff;
  logic [7:0] op_ff;
  logic [7:0] nxt_op;

  assign nxt_op = {rx_ff[6:0], si_s};

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bitcnt_ff <= 8'h00;
      rx_ff <= 64'h0;
      op_ff <= 8'h00;
    end
    else if (cs_n_s)
      bitcnt_ff <= 8'h00; // RULE_19
    else if (sck_rise)
    begin
      rx_ff <= {rx_ff[62:0], si_s};
      if (bitcnt_ff == 8'h07)
        op_ff <= nxt_op;
      if (bitcnt_ff >= BITCNT_CAP)
        bitcnt_ff <= {bitcnt_ff[7:3], bitcnt_ff[2:0] + 3'h1};
      else
        bitcnt_ff <= bitcnt_ff + 8'h01;
    end
  end

  // ==========================================================
  // Protection state
  logic [7:0] cfg_ff;
  logic [63:0] pass_ff;
  logic unlock_ff;
  logic permit_ff;
  logic busy_ff;
  logic p_err_ff;
  logic [31:0] thr_cnt_ff;
  rpl_mode_t mode;
  logic unlock_eff;
  logic permit_eff;
  logic exec;
  logic pass_locked;

  assign mode = cfg_mode(cfg_ff);
  assign pass_locked = !cfg_ff[CFG_MODE_PASS]; // RULE_12
  // Whole bytes only; a partial byte drops the command
  assign exec = cs_rise && bitcnt_ff != 8'h00 &&
                bitcnt_ff[2:0] == 3'h0; // RULE_20
  assign unlock_eff = (mode == RPL_MODE_PERMANENT) ? 1'b0 : unlock_ff; // RULE_06
  assign permit_eff = (mode == RPL_MODE_PASSWORD) ? permit_ff : 1'b1; // RULE_16

  // Non-volatile cells: only 1 to 0, no erase path
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_ff <= CFG_RESET;
      pass_ff <= PASS_RESET; // RULE_11
    end
    else if (exec)
    begin
      if (op_ff == OP_CFG_PROGRAM && bitcnt_ff == LEN_ONE_BYTE &&
          cfg_ff[2:0] == 3'h7)
        cfg_ff <= cfg_ff & rx_ff[7:0]; // RULE_17
      if (op_ff == OP_PASS_PROGRAM && bitcnt_ff == LEN_PASSWORD &&
          !pass_locked)
        pass_ff <= pass_ff & rx_ff; // RULE_10
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      unlock_ff <= 1'b1;
    else if (hw_rst)
      unlock_ff <= (mode == RPL_MODE_LOCKDOWN); // RULE_03 RULE_05
    else if (exec && op_ff == OP_LOCK_REGIONS &&
             bitcnt_ff == LEN_OPCODE)
      unlock_ff <= 1'b0; // RULE_02 RULE_21
    // Of the commands, only a full, matching unlock in password mode sets it
    else if (exec && op_ff == OP_PASS_UNLOCK && bitcnt_ff == LEN_PASSWORD &&
             mode == RPL_MODE_PASSWORD && !busy_ff && rx_ff == pass_ff)
      unlock_ff <= 1'b1; // RULE_04 RULE_09 RULE_23
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      permit_ff <= 1'b1;
    else if (hw_rst || (exec && op_ff == OP_SOFT_RESET &&
                        bitcnt_ff == LEN_OPCODE))
      permit_ff <= cfg_ff[CFG_READ_PASS]; // RULE_08
  end

  // ==========================================================
  // Busy throttle and error flag
  logic unlock_try;
  logic unlock_miss;
  logic guarded_req;
  logic cfg_fail;

  assign unlock_try = exec && op_ff == OP_PASS_UNLOCK &&
                      bitcnt_ff == LEN_PASSWORD &&
                      mode == RPL_MODE_PASSWORD && !busy_ff; // RULE_14
  assign unlock_miss = unlock_try && rx_ff != pass_ff;
  assign guarded_req = exec && (op_ff == OP_REGION_PROGRAM ||
                       op_ff == OP_REGION_ERASE || op_ff == OP_POINTER_SET);
  assign cfg_fail = exec && op_ff == OP_CFG_PROGRAM &&
                    bitcnt_ff == LEN_ONE_BYTE && cfg_ff[2:0] != 3'h7;

  // A match never starts the throttle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_ff <= 1'b0;
      thr_cnt_ff <= 32'h0;
    end
    else if (hw_rst)
    begin
      busy_ff <= 1'b0;
      thr_cnt_ff <= 32'h0;
    end
    else if (unlock_miss)
    begin
      busy_ff <= 1'b1; // RULE_14 RULE_15
      thr_cnt_ff <= 32'h0;
    end
    else if (busy_ff)
    begin
      thr_cnt_ff <= thr_cnt_ff + 32'h1;
      if (thr_cnt_ff == 32'(THROTTLE_CYC - 1))
        busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      p_err_ff <= 1'b0;
    else if (hw_rst)
      p_err_ff <= 1'b0;
    else if (unlock_miss || cfg_fail || (guarded_req && !unlock_eff))
      p_err_ff <= 1'b1; // RULE_01 RULE_13 RULE_22
    else if (exec && op_ff == OP_CLEAR_STATUS && !busy_ff)
      p_err_ff <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      guarded_op_o <= 1'b0;
      guarded_op_code_o <= 8'h00;
    end
    else
    begin
      guarded_op_o <= guarded_req && unlock_eff; // RULE_01
      if (guarded_req)
        guarded_op_code_o <= op_ff;
    end
  end

  // ==========================================================
  // Read answers, shifted out on falling clock edges
  logic [63:0] tx_ff;
  logic so_ff;
  logic [63:0] nxt_tx;
  logic [7:0] state_byte;

  always_comb
  begin
    state_byte = 8'h00;
    state_byte[STATE_UNLOCK_BIT] = unlock_eff;
    state_byte[STATE_PERMIT_BIT] = permit_eff;
    nxt_tx = UNDEF_DATA;
    unique case (nxt_op)
      // Status bytes read as zeros apart from their one flag
      OP_STATUS1_READ:
      begin
        nxt_tx = 64'h0;
        nxt_tx[63 - 7 + STATUS1_WIP_BIT] = busy_ff | p_err_ff;
      end
      OP_STATUS2_READ:
      begin
        nxt_tx = 64'h0;
        nxt_tx[63 - 7 + STATUS2_PERR_BIT] = p_err_ff;
      end
      OP_STATE_READ:
        nxt_tx[63:56] = state_byte;
      OP_CFG_READ:
        nxt_tx[63:56] = cfg_ff;
      OP_PASS_READ:
        nxt_tx = pass_locked ? UNDEF_DATA : pass_ff; // RULE_11 RULE_12
      OP_REGION_READ:
        nxt_tx = permit_eff ? {8{sr3_data_i}} : UNDEF_DATA; // RULE_07
      default:
        nxt_tx = UNDEF_DATA;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_ff <= UNDEF_DATA;
      so_ff <= 1'b1;
    end
    else if (sck_rise && bitcnt_ff == 8'h07)
      tx_ff <= nxt_tx;
    else if (sck_fall && bitcnt_ff >= LEN_OPCODE)
    begin
      so_ff <= tx_ff[63]; // RULE_18
      tx_ff <= {tx_ff[62:0], 1'b1};
    end
  end

  assign link.dev_io_o = {2'b11, so_ff, 1'b1};
  assign link.dev_io_oe_n = {2'b11, cs_n_s, 1'b1}; // RULE_18

  assign region_write_unlock_o = unlock_eff;
  assign region3_read_permit_o = permit_eff;
  assign write_in_progress_o = busy_ff | p_err_ff; // RULE_13
  assign program_error_flag_o = p_err_ff;

endmodule : rpl_device

`default_nettype wire

/* logic/rpl_host.sv */
// Purpose: Host serial controller issuing one framed command at a time
// Assumes: SPI mode 0; sck derived from clk_i by a half-period counter
// Notes: Read data sampled just before each falling edge for margin
`timescale 1ns/10ps
`default_nettype none

module rpl_host
  import rpl_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_CYC_DEF
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  rpl_link_if.host link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_op_i,
  input wire logic [63:0] cmd_wdata_i,
  input wire logic [3:0] cmd_wbytes_i,
  input wire logic [3:0] cmd_rbytes_i,
  input wire logic hw_reset_i,
  output logic [63:0] rd_data_o,
  output logic done_o
);

  generate
    if (HALF_CYC < 4)
    begin : g_bad_half
      $error("HALF_CYC must be at least 4");
    end
  endgenerate

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_HOLD, ST_GAP, ST_RST
  } rpl_hst_t;

  rpl_hst_t state_ff;
  logic [31:0] tmr_ff;
  logic tmr_end;
  logic cs_n_ff;
  logic sck_ff;
  logic si_ff;
  logic rst_n_ff;
  logic [71:0] tx_ff;
  logic [63:0] rx_ff;
  logic [7:0] bits_ff;
  logic [1:0] so_sync_ff;

  assign tmr_end = tmr_ff == 32'(HALF_CYC - 1);

  // ==========================================================
  // Returning data line passes two flip-flops
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      so_sync_ff <= 2'b11;
    else
      so_sync_ff <= {so_sync_ff[0], link.io[IO_SO]};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tmr_ff <= 32'h0;
    else if (state_ff == ST_IDLE || tmr_end)
      tmr_ff <= 32'h0;
    else
      tmr_ff <= tmr_ff + 32'h1;
  end

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      si_ff <= 1'b1;
      rst_n_ff <= 1'b1;
      tx_ff <= 72'h0;
      rx_ff <= 64'h0;
      bits_ff <= 8'h00;
      rd_data_o <= 64'h0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (hw_reset_i)
          begin
            rst_n_ff <= 1'b0;
            state_ff <= ST_RST;
          end
          else if (cmd_valid_i)
          begin
            // Select low a half period before the first rising edge
            cs_n_ff <= 1'b0; // RULE_19
            si_ff <= cmd_op_i[7];
            tx_ff <= {cmd_op_i[6:0], cmd_wdata_i, 1'b1};
            bits_ff <= 8'(({4'h0, cmd_wbytes_i} + {4'h0, cmd_rbytes_i}
                           + 8'h01) << 3); // RULE_20
            state_ff <= ST_SETUP;
          end
        ST_SETUP, ST_LOW:
          if (tmr_end)
          begin
            sck_ff <= 1'b1;
            bits_ff <= bits_ff - 8'h01;
            state_ff <= ST_HIGH;
          end
        ST_HIGH:
          if (tmr_end)
          begin
            sck_ff <= 1'b0;
            rx_ff <= {rx_ff[62:0], so_sync_ff[1]};
            if (bits_ff == 8'h00)
              state_ff <= ST_HOLD;
            else
            begin
              si_ff <= tx_ff[71]; // RULE_18
              tx_ff <= {tx_ff[70:0], 1'b1};
              state_ff <= ST_LOW;
            end
          end
        ST_HOLD:
          if (tmr_end)
          begin
            cs_n_ff <= 1'b1; // RULE_19
            si_ff <= 1'b1;
            state_ff <= ST_GAP;
          end
        ST_GAP:
          if (tmr_end)
          begin
            rd_data_o <= rx_ff;
            done_o <= 1'b1;
            state_ff <= ST_IDLE;
          end
        ST_RST:
          if (tmr_end)
          begin
            rst_n_ff <= 1'b1;
            state_ff <= ST_GAP;
          end
      endcase
    end
  end

  assign cmd_ready_o = state_ff == ST_IDLE && !hw_reset_i;
  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.rst_n = rst_n_ff;
  assign link.host_io_o = {2'b11, 1'b1, si_ff};
  assign link.host_io_oe_n = {2'b00, 1'b1, 1'b0}; // RULE_18

endmodule : rpl_host

`default_nettype wire

/* pkg/rpl_link_if.sv */
// Purpose: Serial link between host controller and protected memory
// Assumes: Each party drives a line only while its enable is low
// Notes: Undriven data lines read high, as with pull-ups
`timescale 1ns/10ps
`default_nettype none

interface rpl_link_if;
  logic cs_n;
  logic sck;
  logic rst_n;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe_n;
  logic [3:0] io;

  // ==========================================================
  // Wire resolution
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_io
      assign io[gi] = !host_io_oe_n[gi] ? host_io_o[gi] :
                      !dev_io_oe_n[gi] ? dev_io_o[gi] : 1'b1;
    end
  endgenerate

  modport host (
    output cs_n,
    output sck,
    output rst_n,
    output host_io_o,
    output host_io_oe_n,
    input io
  );

  modport device (
    input cs_n,
    input sck,
    input rst_n,
    output dev_io_o,
    output dev_io_oe_n,
    input io
  );
endinterface : rpl_link_if

`default_nettype wire

/* pkg/rpl_pkg.sv */
// Purpose: Shared constants for the region password lock link and ends
// Assumes: 125 MHz system clock, SPI mode 0, single-bit transfers
// Notes: Non-volatile cells are modelled in flip-flops set to all ones by rst_i
`default_nettype none

package rpl_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned THROTTLE_US = 100;
  localparam int unsigned THROTTLE_CYC_DEF =
    (THROTTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LINK_PERIOD_NS = 80;
  localparam int unsigned HALF_CYC_DEF = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_LOCK_REGIONS = 8'hA6;
  localparam logic [7:0] OP_PASS_UNLOCK = 8'hEA;
  localparam logic [7:0] OP_PASS_PROGRAM = 8'hE8;
  localparam logic [7:0] OP_PASS_READ = 8'hE7;
  localparam logic [7:0] OP_CFG_PROGRAM = 8'h2F;
  localparam logic [7:0] OP_CFG_READ = 8'h2B;
  localparam logic [7:0] OP_STATE_READ = 8'hA7;
  localparam logic [7:0] OP_STATUS1_READ = 8'h05;
  localparam logic [7:0] OP_STATUS2_READ = 8'h07;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  localparam logic [7:0] OP_REGION_READ = 8'h48;
  localparam logic [7:0] OP_REGION_PROGRAM = 8'h42;
  localparam logic [7:0] OP_REGION_ERASE = 8'h44;
  localparam logic [7:0] OP_POINTER_SET = 8'hFB;

  // ==========================================================
  // Command lengths in bits
  localparam logic [7:0] LEN_OPCODE = 8'h08;
  localparam logic [7:0] LEN_ONE_BYTE = 8'h10;
  localparam logic [7:0] LEN_PASSWORD = 8'h48;
  localparam logic [7:0] BITCNT_CAP = 8'hF8;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned CFG_MODE_PERM = 0;
  localparam int unsigned CFG_MODE_LOCKDOWN = 1;
  localparam int unsigned CFG_MODE_PASS = 2;
  localparam int unsigned CFG_READ_PASS = 6;
  localparam int unsigned STATE_UNLOCK_BIT = 0;
  localparam int unsigned STATE_PERMIT_BIT = 6;
  localparam int unsigned STATUS1_WIP_BIT = 0;
  localparam int unsigned STATUS2_PERR_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [63:0] PASS_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] UNDEF_DATA = 64'hFFFF_FFFF_FFFF_FFFF;

  // Link pin positions on the four data lines
  localparam int unsigned IO_SI = 0;
  localparam int unsigned IO_SO = 1;

  typedef enum logic [1:0] {
    RPL_MODE_LOCKDOWN,
    RPL_MODE_PASSWORD,
    RPL_MODE_PERMANENT
  } rpl_mode_t;

endpackage : rpl_pkg

`default_nettype wire

/* testbench/rpl_link_monitor.sv */
// Purpose: Wire-level checks on the serial link between host and memory
// Assumes: HALF_CYC matches the host instance
// Notes: Watches only interface signals plus clock and reset
`timescale 1ns/10ps
`default_nettype none

module rpl_link_monitor
#(
  parameter int unsigned HALF_CYC = 5
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic rst_n,
  input wire logic [3:0] host_io_oe_n,
  input wire logic [3:0] dev_io_oe_n
);
  // ==========================================================
  // Helper counters
  logic [7:0] hi_cnt_ff;
  logic [7:0] lo_cnt_ff;
  logic [7:0] bit_cnt_ff;
  logic sck_ff;
  logic cs_n_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hi_cnt_ff <= 8'h00;
      lo_cnt_ff <= 8'h00;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
    end
    else
    begin
      hi_cnt_ff <= sck ? hi_cnt_ff + 8'h01 : 8'h00;
      lo_cnt_ff <= !rst_n ? lo_cnt_ff + 8'h01 : 8'h00;
      sck_ff <= sck;
      cs_n_ff <= cs_n;
    end
  end

  // Held one cycle past the rise so the frame length is still visible
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      bit_cnt_ff <= 8'h00;
    else if (!cs_n && sck && !sck_ff)
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
    else if (cs_n && cs_n_ff)
      bit_cnt_ff <= 8'h00;
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_open;
    $fell(cs_n);
  endsequence
  sequence s_sck_quiet;
    !sck [*3];
  endsequence

  property p_frame_start;
    s_frame_open |=> s_sck_quiet;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("clock moved right after select fell");

  property p_idle_clock;
    cs_n |-> !sck;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("serial clock high outside a frame");

  property p_host_lines;
    !host_io_oe_n[0] && host_io_oe_n[1];
  endproperty
  a_host_lines: assert property (p_host_lines)
    else $error("host drives wrong data lines");

  property p_dev_lines;
    cs_n [*3] |-> dev_io_oe_n[1] && dev_io_oe_n[0];
  endproperty
  a_dev_lines: assert property (p_dev_lines)
    else $error("memory drives a line while deselected");

  property p_high_phase;
    $fell(sck) |-> hi_cnt_ff == HALF_CYC[7:0];
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("serial clock high phase has wrong length");

  property p_whole_bytes;
    $rose(cs_n) |-> bit_cnt_ff != 8'h00 && bit_cnt_ff[2:0] == 3'h0;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("frame ended off a byte boundary");

  property p_rst_pulse;
    $rose(rst_n) |-> lo_cnt_ff == HALF_CYC[7:0];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("hardware reset pulse has wrong length");

  property p_rst_no_frame;
    !rst_n |-> cs_n && !sck;
  endproperty
  a_rst_no_frame: assert property (p_rst_no_frame)
    else $error("frame open during hardware reset");

endmodule : rpl_link_monitor

`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench joining host and memory ends
// Assumes: Throttle shortened to THR cycles
// Notes: Power reset also restores configuration and password cells
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) check_val(nm, 64'(e), 64'(g))

module testbench;
  import rpl_pkg::*;
  localparam int unsigned HALF = 5;
  localparam int unsigned THR = 2000;
  localparam logic [63:0] PASSW = 64'h0123_4567_89AB_CDEF;
  logic clk_i;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic hw_reset_i = 1'b0;
  logic [7:0] cmd_op_i = 8'h00;
  logic [7:0] sr3_data_i = 8'h5A;
  logic [63:0] cmd_wdata_i = 64'h0;
  logic [3:0] cmd_wbytes_i = 4'h0;
  logic [3:0] cmd_rbytes_i = 4'h0;
  logic cmd_ready_o, done_o, unlock, permit, gop, write_in_progress, perr;
  logic [63:0] rd_data_o;
  logic [7:0] gcode;
  int bad_count = 0;
  int total_checks = 0;
  int g_cnt = 0;
  int g0;

  rpl_link_if link();
  rpl_host #(.HALF_CYC(HALF)) i_rpl_host (.clk_i(clk_i), .rst_i(rst_i),
    .link(link.host), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_wbytes_i(cmd_wbytes_i), .cmd_rbytes_i(cmd_rbytes_i),
    .hw_reset_i(hw_reset_i), .rd_data_o(rd_data_o), .done_o(done_o));
  rpl_device #(.THROTTLE_CYC(THR)) i_rpl_device (.clk_i(clk_i),
    .rst_i(rst_i), .link(link.device), .sr3_data_i(sr3_data_i),
    .region_write_unlock_o(unlock), .region3_read_permit_o(permit),
    .guarded_op_o(gop), .guarded_op_code_o(gcode),
    .write_in_progress_o(write_in_progress), .program_error_flag_o(perr));
  rpl_link_monitor #(.HALF_CYC(HALF)) i_rpl_link_monitor (.clk_i(clk_i),
    .rst_i(rst_i), .cs_n(link.cs_n), .sck(link.sck), .rst_n(link.rst_n),
    .host_io_oe_n(link.host_io_oe_n), .dev_io_oe_n(link.dev_io_oe_n));

  // ==========================================================
  // Helpers
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (gop === 1'b1)
      g_cnt++;

  task check_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  // Bounded so a dead link cannot stall the run
  task wait_done();
    int n;
    n = 0;
    @(posedge clk_i);
    while (done_o !== 1'b1 && n < 3000)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("done", 1, done_o);
    repeat (6) @(posedge clk_i);
  endtask : wait_done

  task send(input logic [7:0] op, input logic [63:0] wd,
            input logic [3:0] wb, input logic [3:0] rb);
    cmd_op_i <= op;
    cmd_wdata_i <= wd;
    cmd_wbytes_i <= wb;
    cmd_rbytes_i <= rb;
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    wait_done();
  endtask : send

  task hwrst();
    hw_reset_i <= 1'b1;
    @(posedge clk_i);
    hw_reset_i <= 1'b0;
    wait_done();
  endtask : hwrst

  // ==========================================================
  // Scenarios
  task t_lockdown();
    `CHK("unlock", 1, unlock);
    g0 = g_cnt;
    send(OP_REGION_PROGRAM, 64'h0, 4'h0, 4'h0);
    `CHK("guarded", g0 + 1, g_cnt);
    `CHK("code", 8'h42, gcode);
    send(OP_LOCK_REGIONS, 64'h0, 4'h0, 4'h0);
    `CHK("unlock", 0, unlock);
    send(OP_REGION_ERASE, 64'h0, 4'h0, 4'h0);
    `CHK("guarded", g0 + 1, g_cnt);
    send(OP_STATUS2_READ, 64'h0, 4'h0, 4'h1);
    `CHK("status2", 8'h20, rd_data_o[7:0]);
    send(OP_CLEAR_STATUS, 64'h0, 4'h0, 4'h0);
    send(OP_SOFT_RESET, 64'h0, 4'h0, 4'h0);
    send(OP_PASS_UNLOCK, PASS_RESET, 4'h8, 4'h0);
    `CHK("unlock", 0, unlock);
    send(OP_STATE_READ, 64'h0, 4'h0, 4'h1);
    `CHK("state", 8'h40, rd_data_o[7:0]);
    hwrst();
    `CHK("unlock", 1, unlock);
    `CHK("ready", 1, cmd_ready_o);
  endtask : t_lockdown

  task t_password();
    send(OP_PASS_PROGRAM, PASSW, 4'h8, 4'h0);
    send(OP_PASS_PROGRAM, PASS_RESET, 4'h8, 4'h0);
    send(OP_PASS_READ, 64'h0, 4'h0, 4'h8);
    `CHK("password", PASSW, rd_data_o);
    `CHK("perr", 0, perr);
    send(OP_CFG_PROGRAM, {8'hBB, 56'h0}, 4'h1, 4'h0);
    send(OP_CFG_PROGRAM, {8'h00, 56'h0}, 4'h1, 4'h0);
    `CHK("perr", 1, perr);
    send(OP_CFG_READ, 64'h0, 4'h0, 4'h1);
    `CHK("cfg", 8'hBB, rd_data_o[7:0]);
    `CHK("permit", 1, permit);
    send(OP_SOFT_RESET, 64'h0, 4'h0, 4'h0);
    `CHK("permit", 0, permit);
    hwrst();
    `CHK("unlock", 0, unlock);
    `CHK("permit", 0, permit);
    send(OP_REGION_READ, 64'h0, 4'h0, 4'h2);
    `CHK("region3", 16'hFFFF, rd_data_o[15:0]);
    send(OP_PASS_READ, 64'h0, 4'h0, 4'h8);
    `CHK("password", UNDEF_DATA, rd_data_o);
    send(OP_PASS_UNLOCK, PASSW ^ 64'h1, 4'h8, 4'h0);
    `CHK("perr", 1, perr);
    `CHK("wip", 1, write_in_progress);
    send(OP_STATUS1_READ, 64'h0, 4'h0, 4'h1);
    `CHK("status1", 8'h01, rd_data_o[7:0]);
    send(OP_PASS_UNLOCK, PASSW, 4'h8, 4'h0);
    `CHK("unlock", 0, unlock);
    send(OP_CLEAR_STATUS, 64'h0, 4'h0, 4'h0);
    `CHK("perr", 1, perr);
    repeat (THR) @(posedge clk_i);
    send(OP_CLEAR_STATUS, 64'h0, 4'h0, 4'h0);
    `CHK("wip", 0, write_in_progress);
    send(OP_PASS_UNLOCK, PASSW, 4'h7, 4'h0);
    `CHK("unlock", 0, unlock);
    send(OP_PASS_UNLOCK, PASSW, 4'h8, 4'h0);
    `CHK("unlock", 1, unlock);
    `CHK("wip", 0, write_in_progress);
    g0 = g_cnt;
    send(OP_POINTER_SET, 64'h0, 4'h1, 4'h0);
    `CHK("guarded", g0 + 1, g_cnt);
    send(OP_SOFT_RESET, 64'h0, 4'h0, 4'h0);
    `CHK("unlock", 1, unlock);
    `CHK("permit", 0, permit);
    send(OP_LOCK_REGIONS, 64'h0, 4'h0, 4'h0);
    `CHK("unlock", 0, unlock);
  endtask : t_password

  task t_permanent();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    send(OP_CFG_PROGRAM, {8'hFE, 56'h0}, 4'h1, 4'h0);
    `CHK("unlock", 0, unlock);
    hwrst();
    `CHK("permit", 1, permit);
    `CHK("unlock", 0, unlock);
    send(OP_CFG_PROGRAM, {8'hFF, 56'h0}, 4'h1, 4'h0);
    `CHK("perr", 1, perr);
    send(OP_CFG_READ, 64'h0, 4'h0, 4'h1);
    `CHK("cfg", 8'hFE, rd_data_o[7:0]);
    send(OP_REGION_READ, 64'h0, 4'h0, 4'h1);
    `CHK("region3", 8'h5A, rd_data_o[7:0]);
  endtask : t_permanent

  // ==========================================================
  // Run control
  task finish_test();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_lockdown();
    t_password();
    t_permanent();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
